// ===== bench/pmc_pin_model.sv
/* far-side model: interrupt pins, reset pin, pin-change lines, cpu flag.
   assumes the bench calls pulse() to activate one source for n cycles. */
`timescale 1ns/1ps
module pmc_pin_model (
    input wire clk_i, // system clock
    output logic irq0_n_o = 1'b1, // interrupt 0 pin, pulled up
    output logic irq1_n_o = 1'b1, // interrupt 1 pin, pulled up
    output logic rst_n_o = 1'b1, // reset pin, pulled up
    output logic [7:0] pc_o = 8'h00, // pin-change requests
    output logic pend_o = 1'b0 // cpu pending flag
);
    // drive a source active, or release it to its idle level
    task automatic drv(input int src, input logic on);
        case (src)
            0: irq0_n_o <= !on;
            1: irq1_n_o <= !on;
            2: rst_n_o <= !on;
            3: pc_o <= on ? 8'h10 : 8'h00;
            default: pend_o <= on;
        endcase
    endtask
    // level held for the whole requested span before release
    task automatic pulse(input int src, input int n);
        @(posedge clk_i);
        drv(src, 1'b1);
        repeat (n) @(posedge clk_i);
        drv(src, 1'b0);
    endtask
endmodule

// ===== bench/pmc_top_assertions.sv
/* checker on pmc_top ports: clock gating, power-down and wake relations.
   assumes one clock domain and the async active-low reset of the block. */
`timescale 1ns/1ps
module pmc_chk (
    input wire clk_i, // system clock
    input wire resetn_i, // async reset, active low
    input wire irq_pending_i, // pending interrupt
    input wire bod_fuse_i, // detector fused on
    input wire cpu_clk_en_o, // cpu clock enable
    input wire periph_clk_en_o, // peripheral clock enable
    input wire osc_en_o, // oscillator enable
    input wire brownout_detector_en_o, // detector enable
    input wire flash_pwr_en_o, // flash power
    input wire port_hold_o, // port level freeze
    input wire core_reset_o, // internal reset
    input wire wake_irq_o // wake service pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // internal reset steps: its start, then two cycles held
    sequence s_rst_rise; $rose(core_reset_o); endsequence
    sequence s_rst_two; core_reset_o [*2]; endsequence
    // power-down shuts everything but retention
    a_pd_flash_bod: assert property (
        !osc_en_o |-> !flash_pwr_en_o && !brownout_detector_en_o)
        else $error("flash or detector on in power-down");
    a_pd_clocks_off: assert property (
        !osc_en_o |-> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("clock running with oscillator stopped");
    // idle keeps peripherals alive and the detector at its fuse setting
    a_idle_periph_on: assert property (port_hold_o |-> periph_clk_en_o && osc_en_o)
        else $error("peripheral clock stopped in idle");
    a_idle_bod_fuse: assert property (port_hold_o |-> brownout_detector_en_o == bod_fuse_i)
        else $error("detector enable wrong in idle");
    a_idle_cpu_gated: assert property (
        port_hold_o && $past(port_hold_o) |-> !cpu_clk_en_o)
        else $error("cpu clock running in idle");
    a_idle_irq_wake: assert property (port_hold_o && irq_pending_i |-> ##[1:2] !port_hold_o)
        else $error("idle not left on pending interrupt");
    a_wake_cpu_run: assert property ($fell(port_hold_o) |-> ##[0:2] cpu_clk_en_o)
        else $error("cpu clock not back after idle");
    a_wake_pulse_run: assert property (wake_irq_o |-> ##[0:2] cpu_clk_en_o)
        else $error("service pulse without cpu clock");
    // restarted oscillator settles before the cpu sees a clock
    a_restart_gated: assert property ($rose(osc_en_o) |-> !cpu_clk_en_o [*8])
        else $error("cpu clock released at oscillator restart");
    a_reset_two: assert property (s_rst_rise |-> s_rst_two)
        else $error("internal reset shorter than two cycles");
endmodule
bind pmc_top pmc_chk u_chk (.clk_i, .resetn_i, .irq_pending_i, .bod_fuse_i, .cpu_clk_en_o,
    .periph_clk_en_o, .osc_en_o, .brownout_detector_en_o, .flash_pwr_en_o, .port_hold_o,
    .core_reset_o, .wake_irq_o);

// ===== bench/power_mode_controller_bench.sv
/* bench for pmc_top: register access over ahb-lite, idle and power-down.
   assumes pmc_pin_model as far side and SUT_SCALE of 1 (16 cycle start-up). */
`timescale 1ns/1ps
`include "pmc_map.vh"
module power_mode_controller_bench;
    logic clk_i = 1'b0, resetn_i = 1'b0, cold_por_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [31:0] haddr_i = '0, hwdata_i = '0;
    logic [1:0] htrans_i = '0;
    logic e_q = 1'b0, s_q = 1'b0, grp_q = 1'b0;
    logic [7:0] msk_q = '0, lvl_q = '0;
    wire [31:0] hrdata_o;
    wire [7:0] pc;
    wire rdy, resp, i0_n, i1_n, r_n, pend, cpu, per, wdt, osc, brownout_detector, fl, hold, baud, fes;
    int errors = 0, n_checks = 0;
    logic [31:0] r;
    always #25 clk_i = ~clk_i;
    pmc_pin_model pm (.clk_i(clk_i), .irq0_n_o(i0_n), .irq1_n_o(i1_n), .rst_n_o(r_n),
        .pc_o(pc), .pend_o(pend));
    pmc_top #(.SUT_SCALE(1)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .cold_por_i(cold_por_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(rdy), .hrdata_o(hrdata_o),
        .hreadyout_o(rdy), .hresp_o(resp), .ext_irq0_pin_n_i(i0_n), .ext_irq1_pin_n_i(i1_n),
        .ext_reset_pin_n_i(r_n), .pin_change_interrupt_i(pc), .irq_pending_i(pend),
        .ext_irq0_enable_i(e_q), .ext_irq1_enable_i(e_q), .ext_irq0_edge_select_i(s_q),
        .ext_irq1_edge_select_i(s_q), .pin_change_enable_mask_i(msk_q),
        .pin_change_level_i(lvl_q), .pin_change_group_enable_i(grp_q), .sut_fuse_i(2'h0),
        .crystal_i(1'b0), .bod_fuse_i(1'b1), .cpu_clk_en_o(cpu), .periph_clk_en_o(per),
        .wdt_clk_en_o(wdt), .osc_en_o(osc), .brownout_detector_en_o(brownout_detector), .flash_pwr_en_o(fl),
        .port_hold_o(hold), .core_reset_o(), .wake_irq_o(), .baud_double_o(baud),
        .frame_error_select_o(fes));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // wait for a signal to reach a level, bounded
    // sel 0 watches bus ready, sel 1 watches the cpu clock enable
    task automatic wait_hi(input int sel, input int lim, output int k);
        k = 0;
        while (((sel == 0) ? rdy : cpu) !== 1'b1 && k < lim) begin
            @(posedge clk_i);
            k++;
        end
    endtask
    // one ahb single word transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        haddr_i <= {20'h0, a};
        hwrite_i <= wr;
        htrans_i <= 2'b10;
        hsel_i <= 1'b1;
        @(posedge clk_i);
        wait_hi(0, 50, k);
        if (k == 50) chk(0, 1, "bus hang");
        if (k == 50) print_verdict;
        htrans_i <= 2'b00;
        hwdata_i <= d;
        @(posedge clk_i);
        wait_hi(0, 50, k);
        r = hrdata_o;
        chk(resp, 0, "bus response");
        if (k == 50) chk(0, 1, "bus hang");
        if (k == 50) print_verdict;
    endtask
    // enter power-down with one source set up, then wake or force a reset wake
    task automatic pd_case(input int src, n, md, input logic [2:0] cfg, input logic ex, input int mn);
        int k;
        e_q <= cfg[0];
        s_q <= cfg[1];
        grp_q <= cfg[2];
        msk_q <= cfg[0] ? 8'h10 : 8'h00;
        lvl_q <= cfg[1] ? 8'h00 : 8'hff;
        ahb(1'b1, `PMC_OFS_PCTRL_ADDR, {26'h0, md[0], 5'h02});
        repeat (3) @(posedge clk_i);
        chk({osc, fl, brownout_detector, cpu}, 0, "power-down outputs");
        fork pm.pulse(src, n); join_none
        wait_hi(1, 200, k);
        chk(cpu, ex, "wake source");
        if (ex) chk(k >= mn, 1, "wake delay");
        if (!ex) fork pm.pulse(2, 4); join_none
        wait_hi(1, 200, k);
        chk(cpu, 1, "reset wake");
        ahb(1'b0, `PMC_OFS_PCTRL_ADDR, 0);
        chk(r[1:0], 0, "power-down bit after wake");
        $display("test power-down source %0d done", src);
    endtask
    initial begin
        int k;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        ahb(1'b0, `PMC_OFS_PCTRL_ADDR, 0);
        chk(r, 32'h0, "control reset");
        cold_por_i <= 1'b1;
        ahb(1'b0, `PMC_OFS_PCTRL_ADDR, 0);
        cold_por_i <= 1'b0;
        chk(r, 32'h10, "cold power-up flag");
        ahb(1'b1, `PMC_OFS_PCTRL_ADDR, 32'hcc);
        ahb(1'b0, `PMC_OFS_PCTRL_ADDR, 0);
        chk({r, baud, fes}, {32'hcc, 2'b11}, "control write");
        ahb(1'b0, 12'h300, 0);
        chk(r, 32'h0, "unmapped read");
        $display("test registers done");
        for (int w = 0; w < 2; w++) begin
            ahb(1'b1, `PMC_OFS_WAKECFG_ADDR, w);
            ahb(1'b1, `PMC_OFS_PCTRL_ADDR, 32'h01);
            ahb(1'b0, `PMC_OFS_STATUS_ADDR, 0);
            chk({r, hold, cpu, per, wdt, brownout_detector}, {32'h2, 3'b101, w[0], 1'b1}, "idle");
            fork pm.pulse(4, 1); join_none
            wait_hi(1, 50, k);
            ahb(1'b0, `PMC_OFS_PCTRL_ADDR, 0);
            chk({r, hold, cpu}, {32'h0, 2'b01}, "idle wake");
            $display("test idle watchdog %0d done", w);
        end
        pd_case(0, 3, 0, 3'b001, 1'b1, 16);
        pd_case(0, 20, 0, 3'b011, 1'b0, 0);
        pd_case(1, 40, 1, 3'b001, 1'b1, 40);
        pd_case(3, 20, 0, 3'b101, 1'b1, 16);
        pd_case(3, 20, 0, 3'b001, 1'b0, 0);
        pd_case(2, 4, 0, 3'b000, 1'b1, 16);
        pd_case(2, 40, 0, 3'b000, 1'b1, 40);
        print_verdict;
    end
endmodule

// ===== rtl/pmc_map.vh
/*
 power mode controller constants: register offsets, field positions,
 reset values, start-up times per clock source and timing figures.
 assumes a 20 MHz clock and word-aligned ahb-lite register access.
*/
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_OFS_PCTRL 12'h087
`define PMC_OFS_PCTRL_ADDR 12'h21c
`define PMC_OFS_WAKECFG_ADDR 12'h220
`define PMC_OFS_STATUS_ADDR 12'h224
`define PMC_PCTRL_RESET 8'h00
`define PMC_BIT_IDLE 0
`define PMC_BIT_PDOWN 1
`define PMC_BIT_UF0 2
`define PMC_BIT_UF1 3
`define PMC_BIT_POF 4
`define PMC_BIT_WAKEEXT 5
`define PMC_BIT_FES 6
`define PMC_BIT_BAUD 7
`define PMC_WAKECFG_RESET 32'h0000_0000
`define PMC_CLK_MHZ 20
`define PMC_RST_PULSE 2'h2
`define PMC_SUT_RC0 15'h0010
`define PMC_SUT_RC1 15'h0200
`define PMC_SUT_RC2 15'h0400
`define PMC_SUT_RC3 15'h1000
`define PMC_SUT_XT0 15'h0400
`define PMC_SUT_XT1 15'h0800
`define PMC_SUT_XT2 15'h1000
`define PMC_SUT_XT3 15'h4000
`endif

// ===== rtl/pmc_top.v
/*
 power mode controller: power control register over ahb-lite, idle and
 power-down entry, wake detection, start-up timing and cpu clock gating.
 assumes the cpu samples cpu_clk_en_o, wake pins arrive synchronous or
 through the local two-stage synchroniser, and fuses are static levels.
*/
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_top #(
    parameter SUT_SCALE = 20 // cycles per microsecond of start-up delay
) (
    input wire clk_i, // system clock 20 MHz
    input wire resetn_i, // async reset, active low
    input wire cold_por_i, // high for a power-on reset cycle
    input wire hsel_i, // ahb slave select
    input wire [31:0] haddr_i, // ahb address
    input wire [1:0] htrans_i, // ahb transfer type
    input wire hwrite_i, // ahb write
    input wire [2:0] hsize_i, // ahb size
    input wire [31:0] hwdata_i, // ahb write data
    input wire hready_i, // ahb ready in
    output reg [31:0] hrdata_o, // ahb read data
    output reg hreadyout_o, // ahb ready out
    output reg hresp_o, // ahb response, always okay
    input wire ext_irq0_pin_n_i, // external interrupt 0 pin
    input wire ext_irq1_pin_n_i, // external interrupt 1 pin
    input wire ext_reset_pin_n_i, // reset pin
    input wire [7:0] pin_change_interrupt_i, // pin change level requests
    input wire irq_pending_i, // any enabled interrupt pending
    input wire ext_irq0_enable_i, // interrupt 0 enable
    input wire ext_irq1_enable_i, // interrupt 1 enable
    input wire ext_irq0_edge_select_i, // interrupt 0 edge trigger
    input wire ext_irq1_edge_select_i, // interrupt 1 edge trigger
    input wire [7:0] pin_change_enable_mask_i, // pin change enables
    input wire [7:0] pin_change_level_i, // pin change level mode per pin
    input wire pin_change_group_enable_i, // group interrupt enable
    input wire [1:0] sut_fuse_i, // start-up time fuses
    input wire crystal_i, // crystal clock source
    input wire bod_fuse_i, // brown-out detector fused on
    output reg cpu_clk_en_o, // cpu clock enable
    output reg periph_clk_en_o, // peripheral clock enable
    output reg wdt_clk_en_o, // watchdog clock enable
    output reg osc_en_o, // oscillator enable
    output reg brownout_detector_en_o, // detector enable
    output reg flash_pwr_en_o, // flash power
    output reg port_hold_o, // freeze port pin levels
    output reg core_reset_o, // internal cpu reset
    output reg wake_irq_o, // service interrupt on release
    output reg baud_double_o, // uart baud doubling
    output reg frame_error_select_o // uart frame error select
);
    localparam ST_RUN = 6'h01;
    localparam ST_IDLE = 6'h02;
    localparam ST_PDOWN = 6'h04;
    localparam ST_TIMED = 6'h08;
    localparam ST_EXTW = 6'h10;
    localparam ST_RSTP = 6'h20;

    reg [5:0] state_q;
    reg [7:0] pctrl_q;
    reg wdt_idle_q;
    reg [21:0] sut_cnt_q;
    reg [1:0] rpulse_q;
    reg rst_wake_q;
    reg [2:0] wk_s1_q, wk_s2_q;
    reg ad_valid_q, ad_write_q;
    reg [11:0] ad_addr_q;

    // level wake sources qualified by their enables
    wire irq0_wake = ext_irq0_enable_i & ~ext_irq0_edge_select_i & ~ext_irq0_pin_n_i;
    wire irq1_wake = ext_irq1_enable_i & ~ext_irq1_edge_select_i & ~ext_irq1_pin_n_i;
    wire gpi_wake = pin_change_group_enable_i &
        (|(pin_change_interrupt_i & pin_change_enable_mask_i & pin_change_level_i));
    wire [2:0] wk_raw = {~ext_reset_pin_n_i, irq1_wake | irq0_wake, gpi_wake};

    // wake sources pass two flops before use
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wk_s1_q <= 3'h0;
            wk_s2_q <= 3'h0;
        end else begin
            wk_s1_q <= wk_raw;
            wk_s2_q <= wk_s1_q;
        end
    end
    wire rst_low = wk_s2_q[2];
    wire irq_low = wk_s2_q[1] | wk_s2_q[0];

    // start-up delay from fuses and source
    reg [14:0] sut_us;
    always @* begin
        case (sut_fuse_i)
            2'h0: sut_us = crystal_i ? `PMC_SUT_XT0 : `PMC_SUT_RC0;
            2'h1: sut_us = crystal_i ? `PMC_SUT_XT1 : `PMC_SUT_RC1;
            2'h2: sut_us = crystal_i ? `PMC_SUT_XT2 : `PMC_SUT_RC2;
            default: sut_us = crystal_i ? `PMC_SUT_XT3 : `PMC_SUT_RC3;
        endcase
    end
    // full product kept, counter takes the low bits on purpose
    wire [31:0] sut_prod = sut_us * SUT_SCALE;
    wire [21:0] sut_cycles = sut_prod[21:0];

    // ahb address phase capture
    wire ad_take = hsel_i & hready_i & htrans_i[1];
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ad_valid_q <= 1'b0;
            ad_write_q <= 1'b0;
            ad_addr_q <= 12'h000;
        end else if (hready_i) begin
            ad_valid_q <= ad_take;
            ad_write_q <= hwrite_i;
            ad_addr_q <= haddr_i[11:0];
        end
    end
    wire wr_pctrl = ad_valid_q & ad_write_q & (ad_addr_q == `PMC_OFS_PCTRL_ADDR);
    wire wr_cfg = ad_valid_q & ad_write_q & (ad_addr_q == `PMC_OFS_WAKECFG_ADDR);

    // slave answers in one cycle, always okay
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h0000_0000;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (ad_take && !hwrite_i) begin
                case (haddr_i[11:0])
                    `PMC_OFS_PCTRL_ADDR: hrdata_o <= {24'h000000, pctrl_q};
                    `PMC_OFS_WAKECFG_ADDR: hrdata_o <= {31'h0000_0000, wdt_idle_q};
                    `PMC_OFS_STATUS_ADDR: hrdata_o <= {26'h0000000, state_q};
                    default: hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // power control register and mode sequencer
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pctrl_q <= `PMC_PCTRL_RESET;
            wdt_idle_q <= 1'b0;
            state_q <= ST_RUN;
            sut_cnt_q <= 22'h000000;
            rpulse_q <= 2'h0;
            rst_wake_q <= 1'b0;
            wake_irq_o <= 1'b0;
        end else begin
            wake_irq_o <= 1'b0;
            if (wr_cfg)
                wdt_idle_q <= hwdata_i[0];
            case (state_q)
                ST_RUN: begin
                    if (wr_pctrl) begin
                        pctrl_q <= hwdata_i[7:0]; // software may write flag
                        if (hwdata_i[`PMC_BIT_PDOWN])
                            state_q <= ST_PDOWN;
                        else if (hwdata_i[`PMC_BIT_IDLE])
                            state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (irq_pending_i || rst_low) begin
                        pctrl_q[`PMC_BIT_IDLE] <= 1'b0;
                        wake_irq_o <= irq_pending_i & ~rst_low;
                        state_q <= rst_low ? ST_RSTP : ST_RUN;
                        rst_wake_q <= rst_low;
                        rpulse_q <= `PMC_RST_PULSE;
                    end
                end
                ST_PDOWN: begin
                    if (rst_low || irq_low) begin
                        pctrl_q[`PMC_BIT_PDOWN] <= 1'b0;
                        pctrl_q[`PMC_BIT_IDLE] <= 1'b0;
                        rst_wake_q <= rst_low;
                        sut_cnt_q <= sut_cycles;
                        if (!rst_low && pctrl_q[`PMC_BIT_WAKEEXT])
                            state_q <= ST_EXTW;
                        else
                            state_q <= ST_TIMED;
                    end
                end
                ST_TIMED: begin
                    // count runs on even if the pin returns high
                    if (sut_cnt_q > 22'h000001)
                        sut_cnt_q <= sut_cnt_q - 22'h000001;
                    else if (rst_wake_q) begin
                        rpulse_q <= `PMC_RST_PULSE;
                        state_q <= ST_RSTP;
                    end else begin
                        wake_irq_o <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_EXTW: begin
                    // external source holds the pin until stable
                    if (!irq_low) begin
                        wake_irq_o <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_RSTP: begin
                    // hold while pin low, then two-cycle reset
                    if (rst_low)
                        rpulse_q <= `PMC_RST_PULSE;
                    else if (rpulse_q > 2'h1)
                        rpulse_q <= rpulse_q - 2'h1;
                    else begin
                        pctrl_q <= {3'h0, pctrl_q[`PMC_BIT_POF], 4'h0};
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
            // cold power-up set wins over any write or clear in this cycle
            if (cold_por_i)
                pctrl_q[`PMC_BIT_POF] <= 1'b1;
        end
    end

    // clock gates and power enables from state
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            wdt_clk_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            brownout_detector_en_o <= 1'b0;
            flash_pwr_en_o <= 1'b1;
            port_hold_o <= 1'b0;
            core_reset_o <= 1'b0;
            baud_double_o <= 1'b0;
            frame_error_select_o <= 1'b0;
        end else begin
            cpu_clk_en_o <= (state_q == ST_RUN);
            port_hold_o <= (state_q == ST_IDLE);
            periph_clk_en_o <= (state_q != ST_PDOWN);
            wdt_clk_en_o <= (state_q == ST_IDLE) ? wdt_idle_q :
                (state_q != ST_PDOWN);
            osc_en_o <= (state_q != ST_PDOWN);
            flash_pwr_en_o <= (state_q != ST_PDOWN);
            brownout_detector_en_o <= bod_fuse_i & (state_q != ST_PDOWN);
            core_reset_o <= (state_q == ST_RSTP);
            baud_double_o <= pctrl_q[`PMC_BIT_BAUD];
            frame_error_select_o <= pctrl_q[`PMC_BIT_FES];
        end
    end
endmodule
